// [hw/tpf_ctrl.sv]
`timescale 1ns/100ps
`include "tpf_map.svh"

module tpf_ctrl #(
   parameter int AW = 14,
   parameter int AWIDTH = 36,
   parameter int CWIDTH = 18
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic i_port_a_clock,
   input wire logic i_port_b_clock,
   input wire logic i_port_c_clock,
   input wire logic i_master_reset_first_n,
   input wire logic i_master_reset_second_n,
   input wire logic i_partial_reset_or_replay_first_n,
   input wire logic i_partial_reset_or_replay_second_n,
   input wire logic i_replay_mode_select,
   input wire logic i_port_b_read_enable,
   input wire logic i_port_c_write_enable,
   input wire logic i_port_a_direction_select,
   input wire logic i_port_b_width_select,
   input wire logic i_port_c_width_select,
   input wire logic i_port_a_mail_select,
   input wire logic i_port_b_mail_select,
   input wire logic i_port_c_mail_select,
   input wire logic i_byte_order_select,
   input wire tpf_pkg::offset_code_t i_flag_offset_select,
   input wire logic [AWIDTH-1:0] i_port_a_data,
   input wire logic [CWIDTH-1:0] i_port_c_data,
   output logic [AWIDTH-1:0] o_port_a_data,
   output logic o_port_a_data_oe,
   output logic [CWIDTH-1:0] o_port_b_data,
   output logic o_mail_a_to_b_full_flag,
   output logic o_mail_c_to_a_full_flag,
   output logic o_queue_a_to_b_full,
   output logic o_queue_a_to_b_empty,
   output logic o_queue_c_to_a_full,
   output logic o_queue_c_to_a_empty,
   output tpf_pkg::offset_code_t o_cfg_offset_a_to_b,
   output tpf_pkg::offset_code_t o_cfg_offset_c_to_a,
   output tpf_pkg::bus_width_t o_cfg_port_b_width,
   output tpf_pkg::bus_width_t o_cfg_port_c_width,
   output logic o_cfg_byte_order
);
   import tpf_pkg::*;

   localparam int NCTL = 20;
   localparam int NSYN = NCTL + AWIDTH + CWIDTH;

   // -------------------------------------------------------------------
   // Lane helpers for bus matching
   // -------------------------------------------------------------------
   // Bit offset of a part; byte order high sends the top lane first
   function automatic logic [5:0] lane_shift(input logic byte_mode,
                                            input logic order,
                                            input part_t p);
      part_t idx;
      idx = byte_mode ? (order ? 2'h3 - p : p) : (order ? 2'h1 - p : p);
      return byte_mode ? 6'(idx * `TPF_BYTE_BITS)
                       : 6'(idx * `TPF_WORD_BITS);
   endfunction : lane_shift

   function automatic logic [CWIDTH-1:0] get_part(
      input logic [AWIDTH-1:0] w, input logic byte_mode,
      input logic order, input part_t p);
      logic [AWIDTH-1:0] s;
      s = w >> lane_shift(byte_mode, order, p);
      return s[CWIDTH-1:0] & (byte_mode ? `TPF_BYTE_MASK : `TPF_WORD_MASK);
   endfunction : get_part

   function automatic logic [AWIDTH-1:0] put_part(
      input logic [AWIDTH-1:0] w, input logic [CWIDTH-1:0] d,
      input logic byte_mode, input logic order, input part_t p);
      logic [AWIDTH-1:0] m;
      logic [AWIDTH-1:0] v;
      m = AWIDTH'(byte_mode ? `TPF_BYTE_MASK : `TPF_WORD_MASK);
      v = AWIDTH'(d) & m;
      m = m << lane_shift(byte_mode, order, p);
      v = v << lane_shift(byte_mode, order, p);
      return (w & ~m) | v;
   endfunction : put_part

   // -------------------------------------------------------------------
   // Pin synchronisation
   // -------------------------------------------------------------------
   logic [NSYN-1:0] syn;
   logic clk_a_s, clk_b_s, clk_c_s;
   logic mr1_n_s, mr2_n_s, prs1_n_s, prs2_n_s, replay_s;
   logic port_b_read_enable_s, port_c_write_enable_s, dir_s, wsel_b_s, wsel_c_s;
   logic a_msel_s, b_msel_s, c_msel_s, order_s;
   offset_code_t fsel_s;
   logic [AWIDTH-1:0] data_a_s;
   logic [CWIDTH-1:0] data_c_s;

   // Data passes the same two stages as the port clocks, so it is
   // aligned with the edge that the block detects
   tpf_sync #(.W(NSYN)) u_sync (
      .i_clk(i_clk),
      .i_ce(i_ce),
      .i_async({i_port_a_clock, i_port_b_clock, i_port_c_clock,
                i_master_reset_first_n, i_master_reset_second_n,
                i_partial_reset_or_replay_first_n,
                i_partial_reset_or_replay_second_n, i_replay_mode_select,
                i_port_b_read_enable, i_port_c_write_enable,
                i_port_a_direction_select, i_port_b_width_select,
                i_port_c_width_select, i_port_a_mail_select,
                i_port_b_mail_select, i_port_c_mail_select,
                i_byte_order_select, i_flag_offset_select,
                i_port_a_data, i_port_c_data}),
      .o_sync(syn)
   );

   assign {clk_a_s, clk_b_s, clk_c_s, mr1_n_s, mr2_n_s, prs1_n_s,
           prs2_n_s, replay_s, port_b_read_enable_s, port_c_write_enable_s, dir_s, wsel_b_s, wsel_c_s,
           a_msel_s, b_msel_s, c_msel_s, order_s, fsel_s,
           data_a_s, data_c_s} = syn;

   // -------------------------------------------------------------------
   // Edge detection of port clocks and master resets
   // -------------------------------------------------------------------
   logic clk_a_prev_q, clk_b_prev_q, clk_c_prev_q;
   logic mr1_prev_q, mr2_prev_q;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         clk_a_prev_q <= 1'b1;
         clk_b_prev_q <= 1'b1;
         clk_c_prev_q <= 1'b1;
         mr1_prev_q <= 1'b1;
         mr2_prev_q <= 1'b1;
      end else if (i_ce) begin
         clk_a_prev_q <= clk_a_s;
         clk_b_prev_q <= clk_b_s;
         clk_c_prev_q <= clk_c_s;
         mr1_prev_q <= mr1_n_s;
         mr2_prev_q <= mr2_n_s;
      end
   end

   wire a_rise = clk_a_s & ~clk_a_prev_q;
   wire b_rise = clk_b_s & ~clk_b_prev_q;
   wire c_rise = clk_c_s & ~clk_c_prev_q;
   wire mr1_rise = mr1_n_s & ~mr1_prev_q;
   wire mr2_rise = mr2_n_s & ~mr2_prev_q;

   // -------------------------------------------------------------------
   // Reset and replay decode
   // -------------------------------------------------------------------
   // Clear-all covers pointers, output register and mail flag; the
   // rewind term touches the read side only
   wire ab_clr = i_srst |
                 (i_ce & (~mr1_n_s | (~prs1_n_s & ~replay_s)));
   wire ab_rewind = ab_clr | (~prs1_n_s & replay_s);
   wire ca_clr = i_srst |
                 (i_ce & (~mr2_n_s | (~prs2_n_s & ~replay_s)));
   wire ca_rewind = ca_clr | (~prs2_n_s & replay_s);

   // -------------------------------------------------------------------
   // Configuration latched at master reset release
   // -------------------------------------------------------------------
   logic cfg_b_byte_q, cfg_c_byte_q, cfg_order_q;
   offset_code_t cfg_ofs_ab_q, cfg_ofs_ca_q;

   // Partial resets do not reach these registers
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cfg_b_byte_q <= `TPF_CFG_WIDTH_RST;
         cfg_c_byte_q <= `TPF_CFG_WIDTH_RST;
         cfg_order_q <= `TPF_CFG_ORDER_RST;
         cfg_ofs_ab_q <= `TPF_CFG_OFFSET_RST;
         cfg_ofs_ca_q <= `TPF_CFG_OFFSET_RST;
      end else if (i_ce) begin
         if (mr1_rise) begin
            cfg_b_byte_q <= wsel_b_s;
            cfg_c_byte_q <= wsel_c_s;
            cfg_order_q <= order_s;
            cfg_ofs_ab_q <= fsel_s;
         end
         if (mr2_rise) begin
            cfg_ofs_ca_q <= fsel_s;
         end
      end
   end

   // -------------------------------------------------------------------
   // Port operation decode
   // -------------------------------------------------------------------
   logic [AW:0] wr_ab_q, rd_ab_q, wr_ca_q, rd_ca_q;
   logic mail_ab_flag_q, mail_ca_flag_q;
   part_t b_part_q, c_part_q;

   wire ab_empty = (wr_ab_q == rd_ab_q);
   wire ab_full = (wr_ab_q[AW] != rd_ab_q[AW]) &&
                  (wr_ab_q[AW-1:0] == rd_ab_q[AW-1:0]);
   wire ca_empty = (wr_ca_q == rd_ca_q);
   wire ca_full = (wr_ca_q[AW] != rd_ca_q[AW]) &&
                  (wr_ca_q[AW-1:0] == rd_ca_q[AW-1:0]);

   wire a_wr = a_rise & dir_s;
   wire a_rd = a_rise & ~dir_s;
   wire b_rd = b_rise & port_b_read_enable_s;
   wire c_wr = c_rise & port_c_write_enable_s;

   // Mail writes are dropped while the flag shows the register full
   wire ab_mail_wr = a_wr & a_msel_s & mail_ab_flag_q;
   wire ab_mail_rd = b_rd & b_msel_s;
   wire ca_mail_wr = c_wr & c_msel_s & mail_ca_flag_q;
   wire ca_mail_rd = a_rd & a_msel_s;

   wire ab_push = a_wr & ~a_msel_s & ~ab_full;
   wire ab_pop = b_rd & ~b_msel_s & ~ab_empty;
   wire ca_pop = a_rd & ~a_msel_s & ~ca_empty;
   // A port C part is refused whole while the queue is full
   wire ca_part = c_wr & ~c_msel_s & ~ca_full;

   wire b_last = (b_part_q == (cfg_b_byte_q ? `TPF_PART_LAST_BYTE
                                            : `TPF_PART_LAST_WORD));
   wire c_last = (c_part_q == (cfg_c_byte_q ? `TPF_PART_LAST_BYTE
                                            : `TPF_PART_LAST_WORD));
   wire ca_push = ca_part & c_last;

   // -------------------------------------------------------------------
   // Queue storage
   // -------------------------------------------------------------------
   logic [AWIDTH-1:0] ab_rdata, ca_rdata, c_asm_q;
   wire [AWIDTH-1:0] c_merged = put_part(c_asm_q, data_c_s, cfg_c_byte_q,
                                         cfg_order_q, c_part_q);

   tpf_ram #(.AW(AW), .DW(AWIDTH)) u_ram_ab (
      .i_clk(i_clk),
      .i_ce(i_ce),
      .i_we(ab_push & ~ab_clr),
      .i_waddr(wr_ab_q[AW-1:0]),
      .i_wdata(data_a_s),
      .i_raddr(rd_ab_q[AW-1:0]),
      .o_rdata(ab_rdata)
   );

   tpf_ram #(.AW(AW), .DW(AWIDTH)) u_ram_ca (
      .i_clk(i_clk),
      .i_ce(i_ce),
      .i_we(ca_push & ~ca_clr),
      .i_waddr(wr_ca_q[AW-1:0]),
      .i_wdata(c_merged),
      .i_raddr(rd_ca_q[AW-1:0]),
      .o_rdata(ca_rdata)
   );

   // -------------------------------------------------------------------
   // A-to-B queue pointers and port B output register
   // -------------------------------------------------------------------
   logic [CWIDTH-1:0] b_out_q;

   always_ff @(posedge i_clk) begin
      if (i_ce || i_srst) begin
         if (ab_clr) begin
            wr_ab_q <= '0;
         end else if (ab_push) begin
            wr_ab_q <= wr_ab_q + 1'b1;
         end
         if (ab_rewind) begin
            rd_ab_q <= '0;
            b_part_q <= 2'h0;
         end else if (ab_pop) begin
            b_part_q <= b_last ? 2'h0 : b_part_q + 2'h1;
            if (b_last) begin
               rd_ab_q <= rd_ab_q + 1'b1;
            end
         end
      end
   end

   // Output register clears only on clear-all, a replay keeps it
   always_ff @(posedge i_clk) begin
      if (ab_clr) begin
         b_out_q <= '0;
      end else if (i_ce && ab_pop) begin
         b_out_q <= get_part(ab_rdata, cfg_b_byte_q, cfg_order_q, b_part_q);
      end
   end

   // -------------------------------------------------------------------
   // C-to-A queue pointers, port C assembly, port A output register
   // -------------------------------------------------------------------
   logic [AWIDTH-1:0] a_out_q;

   always_ff @(posedge i_clk) begin
      if (i_ce || i_srst) begin
         if (ca_clr) begin
            wr_ca_q <= '0;
            c_part_q <= 2'h0;
            c_asm_q <= '0;
         end else if (ca_part) begin
            c_asm_q <= c_merged;
            c_part_q <= c_last ? 2'h0 : c_part_q + 2'h1;
            if (c_last) begin
               wr_ca_q <= wr_ca_q + 1'b1;
            end
         end
         if (ca_rewind) begin
            rd_ca_q <= '0;
         end else if (ca_pop) begin
            rd_ca_q <= rd_ca_q + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (ca_clr) begin
         a_out_q <= '0;
      end else if (i_ce && ca_pop) begin
         a_out_q <= ca_rdata;
      end
   end

   // -------------------------------------------------------------------
   // Mail registers and flags
   // -------------------------------------------------------------------
   logic [AWIDTH-1:0] mail_ab_q;
   logic [CWIDTH-1:0] mail_ca_q;

   always_ff @(posedge i_clk) begin
      if (i_ce && ab_mail_wr && !i_srst) begin
         mail_ab_q <= data_a_s;
      end
      if (i_ce && ca_mail_wr && !i_srst) begin
         mail_ca_q <= data_c_s & (cfg_c_byte_q ? `TPF_BYTE_MASK
                                               : `TPF_WORD_MASK);
      end
   end

   // A write that lands with a read keeps the register full: the
   // setting event wins over the clearing one
   always_ff @(posedge i_clk) begin
      if (ab_clr) begin
         mail_ab_flag_q <= `TPF_MAIL_FLAG_RST;
      end else if (i_ce) begin
         if (ab_mail_wr) begin
            mail_ab_flag_q <= 1'b0;
         end else if (ab_mail_rd) begin
            mail_ab_flag_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (ca_clr) begin
         mail_ca_flag_q <= `TPF_MAIL_FLAG_RST;
      end else if (i_ce) begin
         if (ca_mail_wr) begin
            mail_ca_flag_q <= 1'b0;
         end else if (ca_mail_rd) begin
            mail_ca_flag_q <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------
   // Output selection and registered pins
   // -------------------------------------------------------------------
   wire [CWIDTH-1:0] b_mail_view = get_part(mail_ab_q, cfg_b_byte_q,
                                            1'b0, 2'h0);
   wire [CWIDTH-1:0] b_sel = b_msel_s ? b_mail_view : b_out_q;
   wire [AWIDTH-1:0] a_sel = a_msel_s ? AWIDTH'(mail_ca_q)
                                      : a_out_q;

   // One cycle behind the selects; the port clock is far slower
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_port_a_data <= '0;
         o_port_a_data_oe <= 1'b0;
         o_port_b_data <= '0;
         o_queue_a_to_b_full <= 1'b0;
         o_queue_a_to_b_empty <= 1'b1;
         o_queue_c_to_a_full <= 1'b0;
         o_queue_c_to_a_empty <= 1'b1;
      end else if (i_ce) begin
         o_port_a_data <= dir_s ? '0 : a_sel;
         o_port_a_data_oe <= ~dir_s;
         o_port_b_data <= b_sel;
         o_queue_a_to_b_full <= ab_full;
         o_queue_a_to_b_empty <= ab_empty;
         o_queue_c_to_a_full <= ca_full;
         o_queue_c_to_a_empty <= ca_empty;
      end
   end

   assign o_mail_a_to_b_full_flag = mail_ab_flag_q;
   assign o_mail_c_to_a_full_flag = mail_ca_flag_q;
   assign o_cfg_offset_a_to_b = cfg_ofs_ab_q;
   assign o_cfg_offset_c_to_a = cfg_ofs_ca_q;
   assign o_cfg_port_b_width = bus_width_t'(cfg_b_byte_q);
   assign o_cfg_port_c_width = bus_width_t'(cfg_c_byte_q);
   assign o_cfg_byte_order = cfg_order_q;

endmodule : tpf_ctrl

// [hw/tpf_map.svh]
`ifndef TPF_MAP_SVH
`define TPF_MAP_SVH

// ----------------------------------------------------------------------
// Reset values of the latched configuration and the mail flags
// ----------------------------------------------------------------------
`define TPF_CFG_OFFSET_RST 3'h0
`define TPF_CFG_WIDTH_RST 1'h0
`define TPF_CFG_ORDER_RST 1'h0
`define TPF_MAIL_FLAG_RST 1'h1

// ----------------------------------------------------------------------
// Bus matching: last part index and lane geometry
// ----------------------------------------------------------------------
`define TPF_PART_LAST_WORD 2'h1
`define TPF_PART_LAST_BYTE 2'h3
`define TPF_BYTE_BITS 6'h09
`define TPF_WORD_BITS 6'h12
`define TPF_BYTE_MASK 18'h001ff
`define TPF_WORD_MASK 18'h3ffff

`endif

// [hw/tpf_pkg.sv]
package tpf_pkg;

   // -------------------------------------------------------------------
   // Types shared by the control block
   // -------------------------------------------------------------------
   typedef enum logic {
      BUS_WORD = 1'b0,
      BUS_BYTE = 1'b1
   } bus_width_t;

   typedef logic [2:0] offset_code_t;
   typedef logic [1:0] part_t;

endpackage : tpf_pkg

// [hw/tpf_ram.sv]
`timescale 1ns/100ps

// Simple dual-port queue storage, read data from a register
module tpf_ram #(
   parameter int AW = 14,
   parameter int DW = 36
) (
   input wire logic i_clk,
   input wire logic i_ce,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [DW-1:0] i_wdata,
   input wire logic [AW-1:0] i_raddr,
   output logic [DW-1:0] o_rdata
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Write and registered read; same-cycle collision returns old data
   always_ff @(posedge i_clk) begin
      if (i_ce) begin
         if (i_we) begin
            mem[i_waddr] <= i_wdata;
         end
         o_rdata <= mem[i_raddr];
      end
   end

endmodule : tpf_ram

// [hw/tpf_sync.sv]
`timescale 1ns/100ps

// Two-stage synchroniser for a vector of unrelated pin levels
module tpf_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_ce,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);

   logic [W-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge i_clk) begin
      if (i_ce) begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule : tpf_sync

// [tb/tpf_ctrl_chk.sv]
`timescale 1ns/100ps

module tpf_ctrl_chk #(
   parameter int AWIDTH = 36,
   parameter int CWIDTH = 18
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_port_a_clock,
   input wire logic i_port_b_clock,
   input wire logic i_port_c_clock,
   input wire logic i_master_reset_first_n,
   input wire logic i_master_reset_second_n,
   input wire logic i_partial_reset_or_replay_first_n,
   input wire logic i_replay_mode_select,
   input wire logic i_port_b_read_enable,
   input wire logic i_port_c_write_enable,
   input wire logic i_port_a_direction_select,
   input wire logic i_port_b_width_select,
   input wire logic i_port_a_mail_select,
   input wire logic i_port_b_mail_select,
   input wire logic i_port_c_mail_select,
   input wire logic [AWIDTH-1:0] o_port_a_data,
   input wire logic o_port_a_data_oe,
   input wire logic [CWIDTH-1:0] o_port_b_data,
   input wire logic o_mail_a_to_b_full_flag,
   input wire logic o_mail_c_to_a_full_flag,
   input wire tpf_pkg::bus_width_t o_cfg_port_b_width
);
   import tpf_pkg::*;
   // -------------------------------------------------------------------
   // Pin-level checks; windows allow for the two-stage synchronisers
   // -------------------------------------------------------------------
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);

   // Port clock rises that start a mail write
   sequence s_a_mail_write;
      $rose(i_port_a_clock) && i_port_a_direction_select &&
         i_port_a_mail_select;
   endsequence
   sequence s_c_mail_write;
      $rose(i_port_c_clock) && i_port_c_write_enable && i_port_c_mail_select;
   endsequence

   AST_MAIL_AB_SET: assert property (
      s_a_mail_write ##0 (o_mail_a_to_b_full_flag && i_master_reset_first_n
         && i_partial_reset_or_replay_first_n)
      |-> ##[1:4] !o_mail_a_to_b_full_flag)
      else $error("a-to-b mail flag did not drop");
   AST_MAIL_AB_CLR: assert property (
      $rose(i_port_b_clock) && i_port_b_read_enable && i_port_b_mail_select
      |-> ##[1:4] o_mail_a_to_b_full_flag)
      else $error("a-to-b mail flag did not rise");
   AST_MAIL_CA_SET: assert property (
      s_c_mail_write ##0 (o_mail_c_to_a_full_flag && i_master_reset_second_n)
      |-> ##[1:4] !o_mail_c_to_a_full_flag)
      else $error("c-to-a mail flag did not drop");
   AST_MAIL_CA_CLR: assert property (
      $rose(i_port_a_clock) && !i_port_a_direction_select &&
         i_port_a_mail_select |-> ##[1:4] o_mail_c_to_a_full_flag)
      else $error("c-to-a mail flag did not rise");
   AST_MRST_AB: assert property (
      !i_master_reset_first_n [*4]
      |-> o_mail_a_to_b_full_flag && o_port_b_data == '0)
      else $error("first master reset did not clear");
   AST_MRST_CA: assert property (
      !i_master_reset_second_n [*4]
      |-> o_mail_c_to_a_full_flag && o_port_a_data == '0)
      else $error("second master reset did not clear");
   AST_PRST_AB: assert property (
      (!i_partial_reset_or_replay_first_n && !i_replay_mode_select) [*5]
      |-> o_mail_a_to_b_full_flag && o_port_b_data == '0)
      else $error("first partial reset did not clear");
   AST_DIR_OFF: assert property (
      i_port_a_direction_select [*4]
      |-> !o_port_a_data_oe && o_port_a_data == '0)
      else $error("port a driven while writing");
   AST_CFG_LATCH: assert property (
      $rose(i_master_reset_first_n)
      |-> ##[3:6] o_cfg_port_b_width == i_port_b_width_select)
      else $error("port b width not latched");
   AST_CFG_KEEP: assert property (
      i_master_reset_first_n [*8] |-> $stable(o_cfg_port_b_width))
      else $error("port b width changed");
endmodule : tpf_ctrl_chk

bind tpf_ctrl tpf_ctrl_chk #(.AWIDTH(AWIDTH), .CWIDTH(CWIDTH)) tpf_ctrl_chk_i (
   .i_clk(i_clk), .i_srst(i_srst), .i_port_a_clock(i_port_a_clock),
   .i_port_b_clock(i_port_b_clock), .i_port_c_clock(i_port_c_clock),
   .i_master_reset_first_n(i_master_reset_first_n),
   .i_master_reset_second_n(i_master_reset_second_n),
   .i_partial_reset_or_replay_first_n(i_partial_reset_or_replay_first_n),
   .i_replay_mode_select(i_replay_mode_select),
   .i_port_b_read_enable(i_port_b_read_enable),
   .i_port_c_write_enable(i_port_c_write_enable),
   .i_port_a_direction_select(i_port_a_direction_select),
   .i_port_b_width_select(i_port_b_width_select),
   .i_port_a_mail_select(i_port_a_mail_select),
   .i_port_b_mail_select(i_port_b_mail_select),
   .i_port_c_mail_select(i_port_c_mail_select),
   .o_port_a_data(o_port_a_data), .o_port_a_data_oe(o_port_a_data_oe),
   .o_port_b_data(o_port_b_data),
   .o_mail_a_to_b_full_flag(o_mail_a_to_b_full_flag),
   .o_mail_c_to_a_full_flag(o_mail_c_to_a_full_flag),
   .o_cfg_port_b_width(o_cfg_port_b_width));

// [tb/tpf_far_side.sv]
`timescale 1ns/100ps

module tpf_far_side (
   output logic o_port_a_clock,
   output logic o_port_b_clock,
   output logic o_port_c_clock
);
   // -------------------------------------------------------------------
   // Port clocks of the outside parties
   // -------------------------------------------------------------------
   // Clocks stand low between transfers; port A has no enable, so a
   // free-running clock would push or pop on every edge
   initial begin
      {o_port_c_clock, o_port_b_clock, o_port_a_clock} = 3'h0;
   end

   // One 800 ns period on the ports in the mask; odd phase to i_clk
   task pulse(input logic [2:0] m);
      #337;
      {o_port_c_clock, o_port_b_clock, o_port_a_clock} = m;
      #400;
      {o_port_c_clock, o_port_b_clock, o_port_a_clock} = 3'h0;
      #63;
   endtask : pulse

   // More than four rises on every port while master reset is low
   task reset_edges();
      repeat (5) pulse(3'h7);
   endtask : reset_edges
endmodule : tpf_far_side

// [tb/triple_port_fifo_control_test.sv]
`timescale 1ns/100ps

module triple_port_fifo_control_test;
   import tpf_pkg::*;
   logic clk, srst, ce, mr1, mr2, pr1, pr2, replay_mode_select, ren, wen, dir;
   logic szb, szc, ma, mb, mc, bo, oea, fab, fca, abf, abe, caf, cae, cbo;
   logic [2:0] fo;
   logic [35:0] da, qa;
   logic [17:0] dc, qb;
   wire logic ca, cb, cc;
   offset_code_t oab, oca;
   bus_width_t wb, wc;
   int err_count = 0;
   int total_checks = 0;
   localparam logic [35:0] WORD = 36'h987654321;

   tpf_far_side tpf_far_side_i (.o_port_a_clock(ca), .o_port_b_clock(cb),
      .o_port_c_clock(cc));
   tpf_ctrl #(.AW(4)) tpf_ctrl_i (.i_clk(clk), .i_srst(srst), .i_ce(ce),
      .i_port_a_clock(ca), .i_port_b_clock(cb), .i_port_c_clock(cc),
      .i_master_reset_first_n(mr1), .i_master_reset_second_n(mr2),
      .i_partial_reset_or_replay_first_n(pr1),
      .i_partial_reset_or_replay_second_n(pr2),
      .i_replay_mode_select(replay_mode_select), .i_port_b_read_enable(ren),
      .i_port_c_write_enable(wen), .i_port_a_direction_select(dir),
      .i_port_b_width_select(szb), .i_port_c_width_select(szc),
      .i_port_a_mail_select(ma), .i_port_b_mail_select(mb),
      .i_port_c_mail_select(mc), .i_byte_order_select(bo),
      .i_flag_offset_select(fo), .i_port_a_data(da), .i_port_c_data(dc),
      .o_port_a_data(qa), .o_port_a_data_oe(oea), .o_port_b_data(qb),
      .o_mail_a_to_b_full_flag(fab), .o_mail_c_to_a_full_flag(fca),
      .o_queue_a_to_b_full(abf), .o_queue_a_to_b_empty(abe),
      .o_queue_c_to_a_full(caf), .o_queue_c_to_a_empty(cae),
      .o_cfg_offset_a_to_b(oab), .o_cfg_offset_c_to_a(oca),
      .o_cfg_port_b_width(wb), .o_cfg_port_c_width(wc),
      .o_cfg_byte_order(cbo));

   // -------------------------------------------------------------------
   // Shared helpers
   // -------------------------------------------------------------------
   // System clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Hang guard, far beyond the roughly 29 us that the tests need
   initial begin
      #500000;
      err_count++;
      results();
   end

   task results();
      if (err_count == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results

   task chk(input logic [35:0] s, input logic [35:0] e);
      total_checks++;
      if (s !== e) begin
         err_count++;
         $display("Error t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk

   task w(input int n);
      repeat (n) @(negedge clk);
   endtask : w

   // One port clock period, then time for the detect and output update
   task port(input logic [2:0] m);
      tpf_far_side_i.pulse(m);
      w(3);
   endtask : port

   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   task t_reset();
      w(10);
      srst = 1'b0;
      tpf_far_side_i.reset_edges();
      w(2);
      chk(fab, 1'b1);
      chk(fca, 1'b1);
      chk(qb, '0);
      chk(qa, '0);
      mr1 = 1'b1;
      mr2 = 1'b1;
      w(6);
      chk(wb, BUS_BYTE);
      chk(wc, BUS_WORD);
      chk(oab, 3'h5);
      chk(oca, 3'h5);
      chk(abe, 1'b1);
      chk(cbo, 1'b0);
      chk(abf, 1'b0);
      chk(caf, 1'b0);
   endtask : t_reset

   // Mail A to B: second write refused, disabled read ignored
   task t_mail_ab();
      dir = 1'b1;
      ma = 1'b1;
      mb = 1'b1;
      da = 36'h123456789;
      port(3'h1);
      chk(fab, 1'b0);
      da = 36'h0000000aa;
      port(3'h1);
      port(3'h2);
      chk(fab, 1'b0);
      ren = 1'b1;
      port(3'h2);
      chk(fab, 1'b1);
      chk(qb[8:0], 9'h189);
      ren = 1'b0;
   endtask : t_mail_ab

   // Mail C to A read back on port A
   task t_mail_ca();
      dc = 18'h2abcd;
      port(3'h4);
      chk(fca, 1'b1);
      wen = 1'b1;
      port(3'h4);
      chk(fca, 1'b0);
      dc = 18'h00011;
      port(3'h4);
      wen = 1'b0;
      dir = 1'b0;
      port(3'h1);
      chk(fca, 1'b1);
      chk(qa, 36'h00002abcd);
      chk(oea, 1'b1);
      dir = 1'b1;
      w(4);
      chk(oea, 1'b0);
   endtask : t_mail_ca

   // Byte lanes on port B, then replay and partial reset
   task t_queue_ab();
      ma = 1'b0;
      mb = 1'b0;
      da = WORD;
      port(3'h1);
      ren = 1'b1;
      for (int i = 0; i < 4; i++) begin
         port(3'h2);
         chk(qb[8:0], 9'(WORD >> (9 * i)));
      end
      chk(abe, 1'b1);
      replay_mode_select = 1'b1;
      pr1 = 1'b0;
      w(5);
      pr1 = 1'b1;
      w(5);
      chk(abe, 1'b0);
      port(3'h2);
      chk(qb[8:0], 9'(WORD));
      ren = 1'b0;
      replay_mode_select = 1'b0;
      pr1 = 1'b0;
      w(5);
      chk(qb, '0);
      chk(abe, 1'b1);
      pr1 = 1'b1;
      w(5);
      chk(wb, BUS_BYTE);
      chk(oab, 3'h5);
   endtask : t_queue_ab

   // Two word writes make one C-to-A entry; partial reset empties it
   task t_queue_ca();
      wen = 1'b1;
      port(3'h4);
      mc = 1'b0;
      port(3'h4);
      port(3'h4);
      chk(cae, 1'b0);
      chk(fca, 1'b0);
      wen = 1'b0;
      dir = 1'b0;
      port(3'h1);
      chk(qa, 36'h000440011);
      dir = 1'b1;
      replay_mode_select = 1'b1;
      pr2 = 1'b0;
      w(5);
      chk(cae, 1'b0);
      chk(fca, 1'b0);
      replay_mode_select = 1'b0;
      w(5);
      chk(fca, 1'b1);
      chk(cae, 1'b1);
      pr2 = 1'b1;
   endtask : t_queue_ca

   // Main sequence; configuration pins stay fixed all run
   initial begin
      {srst, ce, szb, pr1, pr2, mc, dir} = 7'h7f;
      {mr1, mr2, replay_mode_select, ren, wen, szc, ma, mb, bo} = 9'h000;
      fo = 3'h5;
      da = '0;
      dc = '0;
      t_reset();
      t_mail_ab();
      t_mail_ca();
      t_queue_ab();
      t_queue_ca();
      results();
   end
endmodule : triple_port_fifo_control_test
